/* core/scpm_params.svh */
//
// Purpose: constants of the system clock select and power mode block
// Assumes: one 40 MHz clock; registers reached over a plain strobe port
// Notes:   fields are bit positions inside the 8-bit registers
//
// Contract
// - select low: divide code 000/001 low clock, 010..111 high /64../2
// - high clock select high: undivided high clock, divide code ignored
// - switching to low clock stops the high oscillator and its dividers
// - low ready reads low in deep sleep, rises LOW_DIV cycles (one low clock period) after wake
// - high ready cleared at power-on, set once the oscillator is stable
// - halt enters idle when idle-on-halt is 1, else sleep; bit resets to 1
// - idle keeps system clock if sysclk-in-idle bit 7 high, else stops it
// - sleep is deep if watchdog off, watchdog sleep if watchdog on
// - deep sleep stops sys, watchdog, time base clocks; clears watchdog
// - watchdog sleep stops sys and time base; watchdog runs on low clock
// - unclocked idle stops system clock and CPU, time base keeps running
// - clocked idle stops program but keeps system and time base clocks
// - sleep and idle keep memory, registers and port states unchanged
// - any halt entry sets powerdown flag and clears watchdog timeout flag; a timeout in the entry cycle leaves that flag set
// - watchdog sleep or idle entry clears watchdog, which keeps counting
// - brownout flag bit 2: software may clear it, never set it
// - watchdog control reset flag bit 0: hardware sets, software clears
// - switch into slow mode waits until the low oscillator reports ready
// - unimplemented bits read zero: control bit 4, aux bits 6..4 and 1
//
`ifndef SCPM_PARAMS_SVH
`define SCPM_PARAMS_SVH

// ---------------------------------------------------------------
// register map
// ---------------------------------------------------------------
`define SCPM_ADDR_W     4
`define SCPM_CTRL_ADDR  4'h0
`define SCPM_AUX_ADDR   4'h1
`define SCPM_CTRL_RST   8'h03
`define SCPM_AUX_RST    8'h00

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define SCPM_DIV_MSB    7
`define SCPM_DIV_LSB    5
`define SCPM_LRDY_BIT   3
`define SCPM_HRDY_BIT   2
`define SCPM_IDLE_BIT   1
`define SCPM_HSEL_BIT   0
`define SCPM_FSYS_BIT   7
`define SCPM_D3_BIT     3
`define SCPM_BROWN_BIT  2
`define SCPM_WDRST_BIT  0
`define SCPM_CTRL_RSVD  8'h10
`define SCPM_AUX_RSVD   8'h72

// ---------------------------------------------------------------
// selector codes and timing
// ---------------------------------------------------------------
`define SCPM_SEL_LOW    3'h0
`define SCPM_SEL_FULL   3'h7
`define SCPM_DIV_MASK   6'h3f
`define SCPM_SYS_MHZ    40
`define SCPM_SYS_HZ     40000000
`define SCPM_HIGH_HZ    8000000
`define SCPM_LOW_HZ     32000
`define SCPM_HSTAB_NS   1600

`endif

/* core/scpm_pkg.sv */
//
// Purpose: types of the system clock select and power mode block
// Assumes: constants live in scpm_params.svh
// Notes:   mode codes are one-hot
//
`include "scpm_params.svh"

package scpm_pkg;

  typedef enum logic [4:0] {
    MODE_RUN        = 5'h01,
    MODE_DEEP_SLEEP = 5'h02,
    MODE_WDT_SLEEP  = 5'h04,
    MODE_IDLE_UNCLK = 5'h08,
    MODE_IDLE_CLK   = 5'h10
  } scpm_mode_t;

  typedef struct packed {
    logic [`SCPM_ADDR_W-1:0] addr;
    logic [7:0]              wdata;
    logic                    we;
    logic                    re;
  } scpm_bus_req_t;

  typedef struct packed {
    logic sys;
    logic cpu;
    logic tbc;
    logic wdt;
    logic high;
  } scpm_clk_en_t;

endpackage

/* core/scpm_top.sv */
//
// Purpose: system clock selection, oscillator control and halt power modes
// Assumes: clocks leave as one-cycle enables of sys_clk; all inputs are
//          synchronous to sys_clk
// Notes:   oscillators are modelled by dividers of sys_clk
//
`timescale 1ns/1ps
`default_nettype none
`include "scpm_params.svh"

module scpm_top #(
  parameter int HIGH_DIV  = `SCPM_SYS_HZ / `SCPM_HIGH_HZ,
  parameter int LOW_DIV   = `SCPM_SYS_HZ / `SCPM_LOW_HZ,
  parameter int HSTAB_CYC = (`SCPM_HSTAB_NS * `SCPM_SYS_MHZ + 999) / 1000
) (
  // clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  rst_n,
  // register port
  input  wire scpm_pkg::scpm_bus_req_t bus_req,
  output var  logic [7:0]            rdata,
  // cpu and watchdog events
  input  wire logic                  halt_req,
  input  wire logic                  wake_req,
  input  wire logic                  wdt_enabled,
  input  wire logic                  wdt_ctrl_reset_evt,
  input  wire logic                  brownout_evt,
  input  wire logic                  wdt_timeout_evt,
  input  wire logic                  clr_wdt_req,
  // clock enables and status
  output var  scpm_pkg::scpm_clk_en_t clk_en,
  output var  logic                  high_osc_on,
  output var  logic                  low_osc_on,
  output var  logic                  wdt_clear,
  output var  logic                  wdt_halt,
  output var  logic                  powerdown_flag,
  output var  logic                  watchdog_timeout_flag,
  output var  scpm_pkg::scpm_mode_t  mode
);
  import scpm_pkg::*;

  localparam int LW = $clog2(LOW_DIV);
  localparam int HW = (HIGH_DIV > 1) ? $clog2(HIGH_DIV) : 1;
  localparam int SW = $clog2(HSTAB_CYC + 1);

  // ---------------------------------------------------------------
  // helper functions
  // ---------------------------------------------------------------
  // 0 = low clock, 1..6 = high /64../2, 7 = high undivided
  function automatic logic [2:0] sel_of(input logic hl,
                                        input logic [2:0] code);
    if (hl)
      sel_of = `SCPM_SEL_FULL;
    else if (code[2:1] == 2'h0)
      sel_of = `SCPM_SEL_LOW;
    else
      sel_of = code - 3'h1;
  endfunction

  function automatic logic src_tick(input logic [2:0] sel,
                                    input logic lo,
                                    input logic hi,
                                    input logic [5:0] cnt);
    logic [5:0] m;
    m = `SCPM_DIV_MASK >> (sel - 3'h1);
    if (sel == `SCPM_SEL_LOW)
      src_tick = lo;
    else if (sel == `SCPM_SEL_FULL)
      src_tick = hi;
    else
      src_tick = hi && ((cnt & m) == m);
  endfunction

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  logic [2:0] clock_divide_select_r;
  logic       idle_on_halt_r;
  logic       high_clock_select_r;
  logic       sysclk_in_idle_r;
  logic       aux_d3_r;
  logic       brownout_reset_flag_r;
  logic       wdt_ctrl_reset_flag_r;
  logic       low_osc_ready_r;
  logic       high_osc_ready_r;
  logic [2:0] cur_sel_r;
  logic [5:0] hdiv_cnt_r;
  logic [LW-1:0] lo_cnt_r;
  logic [HW-1:0] hi_cnt_r;
  logic [SW-1:0] stab_cnt_r;
  scpm_mode_t    mode_r;

  logic          wr_ctrl;
  logic          wr_aux;
  logic [2:0]    req_sel;
  logic          lo_tick;
  logic          hi_tick;
  logic          cur_tick;
  logic          tgt_ready;
  logic          halt_take;
  logic          hosc_run;
  logic          losc_run;
  scpm_mode_t    halt_mode;

  assign wr_ctrl = bus_req.we && (bus_req.addr == `SCPM_CTRL_ADDR);
  assign wr_aux  = bus_req.we && (bus_req.addr == `SCPM_AUX_ADDR);
  assign req_sel = sel_of(high_clock_select_r, clock_divide_select_r);

  // ---------------------------------------------------------------
  // control register writes
  // ---------------------------------------------------------------
  // registers keep their value in every halt mode; only writes alter them
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      clock_divide_select_r <= 3'(`SCPM_CTRL_RST >> `SCPM_DIV_LSB);
      idle_on_halt_r        <= 1'(`SCPM_CTRL_RST >> `SCPM_IDLE_BIT);
      high_clock_select_r   <= 1'(`SCPM_CTRL_RST >> `SCPM_HSEL_BIT);
    end else if (wr_ctrl) begin
      clock_divide_select_r <= bus_req.wdata[`SCPM_DIV_MSB:`SCPM_DIV_LSB];
      idle_on_halt_r        <= bus_req.wdata[`SCPM_IDLE_BIT];
      high_clock_select_r   <= bus_req.wdata[`SCPM_HSEL_BIT];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sysclk_in_idle_r <= 1'(`SCPM_AUX_RST >> `SCPM_FSYS_BIT);
      aux_d3_r         <= 1'(`SCPM_AUX_RST >> `SCPM_D3_BIT);
    end else if (wr_aux) begin
      sysclk_in_idle_r <= bus_req.wdata[`SCPM_FSYS_BIT];
      aux_d3_r         <= bus_req.wdata[`SCPM_D3_BIT];
    end
  end

  // ---------------------------------------------------------------
  // sticky reset flags
  // ---------------------------------------------------------------
  // hardware set wins over a software clear in the same cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      brownout_reset_flag_r <= 1'(`SCPM_AUX_RST >> `SCPM_BROWN_BIT);
    else if (brownout_evt)
      brownout_reset_flag_r <= 1'b1;
    else if (wr_aux && !bus_req.wdata[`SCPM_BROWN_BIT])
      brownout_reset_flag_r <= 1'b0;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      wdt_ctrl_reset_flag_r <= 1'(`SCPM_AUX_RST >> `SCPM_WDRST_BIT);
    else if (wdt_ctrl_reset_evt)
      wdt_ctrl_reset_flag_r <= 1'b1;
    else if (wr_aux && !bus_req.wdata[`SCPM_WDRST_BIT])
      wdt_ctrl_reset_flag_r <= 1'b0;
  end

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (bus_req.re) begin
      rdata <= 8'h00;
      if (bus_req.addr == `SCPM_CTRL_ADDR) begin
        rdata[`SCPM_DIV_MSB:`SCPM_DIV_LSB] <= clock_divide_select_r;
        rdata[`SCPM_LRDY_BIT] <= low_osc_ready_r;
        rdata[`SCPM_HRDY_BIT] <= high_osc_ready_r;
        rdata[`SCPM_IDLE_BIT] <= idle_on_halt_r;
        rdata[`SCPM_HSEL_BIT] <= high_clock_select_r;
      end else if (bus_req.addr == `SCPM_AUX_ADDR) begin
        rdata[`SCPM_FSYS_BIT]  <= sysclk_in_idle_r;
        rdata[`SCPM_D3_BIT]    <= aux_d3_r;
        rdata[`SCPM_BROWN_BIT] <= brownout_reset_flag_r;
        rdata[`SCPM_WDRST_BIT] <= wdt_ctrl_reset_flag_r;
      end
    end else begin
      rdata <= 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // power mode sequencer
  // ---------------------------------------------------------------
  assign halt_take = halt_req && (mode_r == MODE_RUN);

  always_comb begin
    if (idle_on_halt_r) begin
      halt_mode = sysclk_in_idle_r ? MODE_IDLE_CLK : MODE_IDLE_UNCLK;
    end else begin
      halt_mode = wdt_enabled ? MODE_WDT_SLEEP : MODE_DEEP_SLEEP;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_r <= MODE_RUN;
    end else begin
      unique case (mode_r)
        MODE_RUN: begin
          if (halt_req)
            mode_r <= halt_mode;
        end
        MODE_DEEP_SLEEP,
        MODE_WDT_SLEEP,
        MODE_IDLE_UNCLK,
        MODE_IDLE_CLK: begin
          if (wake_req)
            mode_r <= MODE_RUN;
        end
      endcase
    end
  end

  // halt flags: a timeout in the entry cycle still sets its flag
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      powerdown_flag <= 1'b0;
    else if (halt_take)
      powerdown_flag <= 1'b1;
    else if (clr_wdt_req)
      powerdown_flag <= 1'b0;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      watchdog_timeout_flag <= 1'b0;
    else if (wdt_timeout_evt)
      watchdog_timeout_flag <= 1'b1;
    else if (halt_take)
      watchdog_timeout_flag <= 1'b0;
  end

  // watchdog counter clears on every halt entry; only deep sleep halts it
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wdt_clear <= 1'b0;
      wdt_halt  <= 1'b0;
    end else begin
      wdt_clear <= halt_take;
      wdt_halt  <= (mode_r == MODE_DEEP_SLEEP);
    end
  end

  // ---------------------------------------------------------------
  // oscillators
  // ---------------------------------------------------------------
  // high oscillator runs only while some running clock still needs it
  assign hosc_run = ((cur_sel_r != `SCPM_SEL_LOW) ||
                     (req_sel != `SCPM_SEL_LOW)) &&
                    ((mode_r == MODE_RUN) || (mode_r == MODE_IDLE_CLK));
  assign losc_run = (mode_r != MODE_DEEP_SLEEP);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lo_cnt_r <= '0;
    end else if (!losc_run) begin
      lo_cnt_r <= '0;
    end else if (lo_cnt_r == LW'(LOW_DIV - 1)) begin
      lo_cnt_r <= '0;
    end else begin
      lo_cnt_r <= lo_cnt_r + LW'(1);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hi_cnt_r <= '0;
    end else if (!hosc_run) begin
      hi_cnt_r <= '0;
    end else if (hi_cnt_r == HW'(HIGH_DIV - 1)) begin
      hi_cnt_r <= '0;
    end else begin
      hi_cnt_r <= hi_cnt_r + HW'(1);
    end
  end

  assign lo_tick = losc_run && (lo_cnt_r == LW'(LOW_DIV - 1));
  assign hi_tick = hosc_run && high_osc_ready_r &&
                   (hi_cnt_r == HW'(HIGH_DIV - 1));

  // prescaler for the divided high clocks stops with the oscillator
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      hdiv_cnt_r <= '0;
    else if (!hosc_run)
      hdiv_cnt_r <= '0;
    else if (hi_tick)
      hdiv_cnt_r <= hdiv_cnt_r + 6'h01;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stab_cnt_r       <= '0;
      high_osc_ready_r <= 1'b0;
    end else if (!hosc_run) begin
      stab_cnt_r       <= '0;
      high_osc_ready_r <= 1'b0;
    end else if (stab_cnt_r == SW'(HSTAB_CYC)) begin
      high_osc_ready_r <= 1'b1;
    end else begin
      stab_cnt_r <= stab_cnt_r + SW'(1);
    end
  end

  // ready on the first low tick after the oscillator restarts
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      low_osc_ready_r <= 1'b0;
    else if (!losc_run)
      low_osc_ready_r <= 1'b0;
    else if (lo_tick)
      low_osc_ready_r <= 1'b1;
  end

  // ---------------------------------------------------------------
  // glitch-free source selection
  // ---------------------------------------------------------------
  // the switch lands on a boundary of the old source, or at once when the old
  // high source is not ready, and only once the new source is ready, so no pulse is ever shortened
  assign cur_tick  = src_tick(cur_sel_r, lo_tick, hi_tick, hdiv_cnt_r);
  assign tgt_ready = (req_sel == `SCPM_SEL_LOW) ? low_osc_ready_r
                                                : high_osc_ready_r;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_sel_r <= `SCPM_SEL_FULL;
    end else if ((req_sel != cur_sel_r) && tgt_ready &&
                 (cur_tick || (cur_sel_r != `SCPM_SEL_LOW &&
                               !high_osc_ready_r))) begin
      cur_sel_r <= req_sel;
    end
  end

  // ---------------------------------------------------------------
  // clock enable outputs
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_en      <= '0;
      high_osc_on <= 1'b0;
      low_osc_on  <= 1'b0;
    end else begin
      clk_en.sys  <= cur_tick && ((mode_r == MODE_RUN) ||
                                  (mode_r == MODE_IDLE_CLK));
      clk_en.cpu  <= cur_tick && (mode_r == MODE_RUN);
      clk_en.tbc  <= lo_tick && ((mode_r == MODE_RUN) ||
                                 (mode_r == MODE_IDLE_UNCLK) ||
                                 (mode_r == MODE_IDLE_CLK));
      clk_en.wdt  <= lo_tick && wdt_enabled;
      clk_en.high <= hi_tick;
      high_osc_on <= hosc_run;
      low_osc_on  <= losc_run;
    end
  end

  assign mode = mode_r;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_deep_clk_stop: assert property (
    (mode_r == MODE_DEEP_SLEEP) |=> !clk_en.sys && !clk_en.tbc &&
                                     !clk_en.wdt && wdt_halt)
    else $error("clock running in deep sleep");

  a_wdt_sleep_keep: assert property (
    (mode_r == MODE_WDT_SLEEP) && lo_tick && wdt_enabled
      |=> clk_en.wdt && !clk_en.tbc && !clk_en.sys)
    else $error("watchdog sleep clocks wrong");

  a_unclk_idle_tb: assert property (
    (mode_r == MODE_IDLE_UNCLK) && lo_tick |=> clk_en.tbc && !clk_en.sys)
    else $error("unclocked idle clocks wrong");

  a_clk_idle_sys: assert property (
    (mode_r == MODE_IDLE_CLK) && cur_tick |=> clk_en.sys && !clk_en.cpu)
    else $error("clocked idle clocks wrong");

  a_halt_mode_pick: assert property (
    halt_take && !idle_on_halt_r |=>
      mode_r == ($past(wdt_enabled) ? MODE_WDT_SLEEP : MODE_DEEP_SLEEP))
    else $error("wrong sleep mode on halt");

  a_idle_mode_pick: assert property (
    halt_take && idle_on_halt_r |=> mode_r ==
      ($past(sysclk_in_idle_r) ? MODE_IDLE_CLK : MODE_IDLE_UNCLK))
    else $error("wrong idle mode on halt");

  a_halt_flags: assert property (
    halt_take && !wdt_timeout_evt |=> powerdown_flag && !watchdog_timeout_flag)
    else $error("halt flags not updated");

  a_halt_wdt_clr: assert property (
    halt_take |=> wdt_clear ##1 !wdt_clear)
    else $error("watchdog clear pulse missing");

  a_low_ready_sleep: assert property (
    (mode_r == MODE_DEEP_SLEEP) ##1 (mode_r == MODE_DEEP_SLEEP)
      |-> !low_osc_ready_r)
    else $error("low ready high in deep sleep");

  a_slow_waits: assert property (
    (cur_sel_r != `SCPM_SEL_LOW) ##1 (cur_sel_r == `SCPM_SEL_LOW)
      |-> $past(low_osc_ready_r))
    else $error("slow switch before low ready");

  a_high_stops: assert property (
    (cur_sel_r == `SCPM_SEL_LOW) && (req_sel == `SCPM_SEL_LOW)
      |=> !high_osc_on && !clk_en.high)
    else $error("high oscillator not stopped");

  a_brown_noset: assert property (
    !brownout_reset_flag_r && !brownout_evt |=> !brownout_reset_flag_r)
    else $error("brownout flag set by software");

  a_wdt_flag_set: assert property (
    wdt_ctrl_reset_evt |=> wdt_ctrl_reset_flag_r)
    else $error("watchdog reset flag not set");

  a_rsvd_zero: assert property (
    bus_req.re |=> (rdata & (($past(bus_req.addr) == `SCPM_AUX_ADDR) ?
                             `SCPM_AUX_RSVD : `SCPM_CTRL_RSVD)) == 8'h00)
    else $error("unimplemented bit reads one");

  c_enter_deep:  cover property (halt_take ##1 mode_r == MODE_DEEP_SLEEP);
  c_enter_idle:  cover property (halt_take ##1 mode_r == MODE_IDLE_CLK);
  c_to_slow:     cover property ((cur_sel_r != `SCPM_SEL_LOW)
                                 ##1 (cur_sel_r == `SCPM_SEL_LOW));
  c_wake_run:    cover property ((mode_r != MODE_RUN) ##1 (mode_r == MODE_RUN));

endmodule

`default_nettype wire

/* verif/scpm_tb.sv */
//
// Purpose: self-checking bench for the clock select and power mode block
// Assumes: oscillator dividers shortened; all stimulus on rising edges
// Notes:   random register traffic from a fixed seed plus halt corners
//
`timescale 1ns/1ps
`default_nettype none
`include "scpm_params.svh"

module testbench;
  import scpm_pkg::*;

  // -------------------------------------------------------------
  // stimulus and observation
  // -------------------------------------------------------------
  // short dividers keep each rate window to a few hundred cycles
  localparam int LDIV = 4;
  localparam int HDIV = 2;
  localparam int WIN  = 512;
  localparam logic [3:0] CA = `SCPM_CTRL_ADDR;
  localparam logic [3:0] AA = `SCPM_AUX_ADDR;

  logic          sys_clk = 1'b0;
  logic          rst_n   = 1'b0;
  scpm_bus_req_t bus_req = '0;
  logic [7:0]    rdata;
  logic [5:0]    ev      = '0;
  logic          wdt_enabled = 1'b0;
  scpm_clk_en_t  clk_en;
  logic          high_osc_on, low_osc_on, wdt_clear, wdt_halt;
  logic          powerdown_flag, watchdog_timeout_flag;
  scpm_mode_t    mode;
  int            n_errors = 0;
  int            compares = 0;
  int            cnt[5];

  always #12.5 sys_clk = ~sys_clk;

  scpm_top #(.HIGH_DIV(HDIV), .LOW_DIV(LDIV), .HSTAB_CYC(3)) uut (
    .sys_clk               (sys_clk),
    .rst_n                 (rst_n),
    .bus_req               (bus_req),
    .rdata                 (rdata),
    .halt_req              (ev[0]),
    .wake_req              (ev[1]),
    .wdt_enabled           (wdt_enabled),
    .wdt_ctrl_reset_evt    (ev[5]),
    .brownout_evt          (ev[4]),
    .wdt_timeout_evt       (ev[2]),
    .clr_wdt_req           (ev[3]),
    .clk_en                (clk_en),
    .high_osc_on           (high_osc_on),
    .low_osc_on            (low_osc_on),
    .wdt_clear             (wdt_clear),
    .wdt_halt              (wdt_halt),
    .powerdown_flag        (powerdown_flag),
    .watchdog_timeout_flag (watchdog_timeout_flag),
    .mode                  (mode)
  );

  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  task automatic finish_test();
    if (n_errors == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string what);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus_req <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
    @(posedge sys_clk);
    bus_req <= '0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    bus_req <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
    @(posedge sys_clk);
    bus_req <= '0;
    #1;
    d = rdata;
  endtask

  task automatic pulse(input int k);
    @(posedge sys_clk);
    ev[k] <= 1'b1;
    @(posedge sys_clk);
    ev <= '0;
    #1;
  endtask

  // cnt index: 4 sys, 3 cpu, 2 time base, 1 watchdog, 0 high
  task automatic count(input int n);
    logic [4:0] e;
    cnt = '{default: 0};
    repeat (n) begin
      @(posedge sys_clk);
      #1;
      e = clk_en;
      for (int k = 0; k < 5; k++)
        if (e[k] === 1'b1) cnt[k]++;
    end
  endtask

  function automatic int period(input logic hl, input logic [2:0] code);
    if (hl) return HDIV;
    if (code < 3'h2) return LDIV;
    return HDIV << (8 - code);
  endfunction

  function automatic scpm_mode_t exp_mode(input logic i, input logic f,
                                          input logic w);
    if (i) return f ? MODE_IDLE_CLK : MODE_IDLE_UNCLK;
    return w ? MODE_WDT_SLEEP : MODE_DEEP_SLEEP;
  endfunction

  // -------------------------------------------------------------
  // tests
  // -------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_errors++;
    finish_test();
  end

  initial begin
    logic [7:0] d, r, cv;
    logic [2:0] code;
    logic       hl, idl, fs, wde;
    scpm_mode_t m;
    int         p;
    void'($urandom(15123));
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (40) @(posedge sys_clk);
    rd(CA, d);
    chk(d & 8'hf3, `SCPM_CTRL_RST, "ctrl reset");
    chk(8'(d[2]), 8'h01, "high ready");
    rd(AA, d);
    chk(d, `SCPM_AUX_RST, "aux reset");
    rd(4'h9, d);
    chk(d, 8'h00, "unmapped read");
    pulse(4);
    pulse(5);
    rd(AA, d);
    chk(d, 8'h05, "flags set");
    wr(AA, 8'h04);
    rd(AA, d);
    chk(d, 8'h04, "wrf clear");
    wr(AA, 8'h00);
    wr(AA, 8'h05);
    rd(AA, d);
    chk(d, 8'h00, "flags not settable");
    // random fills: flags stay clear, unimplemented bits stay zero
    repeat (6) begin
      r = 8'($urandom);
      wr(AA, r);
      rd(AA, d);
      chk(d, r & 8'h88, "aux rw");
      r = 8'($urandom);
      wr(CA, r);
      rd(CA, d);
      chk(d & 8'hf3, r & 8'he3, "ctrl rw");
    end
    for (int c = 0; c < 9; c++) begin
      hl = (c == 8);
      code = hl ? 3'($urandom) : c[2:0];
      wr(CA, {code, 3'b000, 1'b1, hl});
      repeat (300) @(posedge sys_clk);
      count(WIN);
      p = period(hl, code);
      chk(8'(cnt[4] >= WIN / p - 1 && cnt[4] <= WIN / p + 1), 8'h01,
          "sys rate");
      rd(CA, d);
      if (!hl && code < 3'h2) begin
        chk(8'(high_osc_on), 8'h00, "high osc on");
        chk(8'(cnt[0]), 8'h00, "high ticks");
        chk(8'(d[3]), 8'h01, "low ready");
      end else begin
        chk(8'(d[2]), 8'h01, "high ready");
      end
    end
    for (int k = 0; k < 8; k++) begin
      idl = k[0];
      fs = k[1];
      wde = k[2];
      cv = {3'b111, 3'b000, idl, 1'b1};
      wr(CA, cv);
      wr(AA, {fs, 7'h00});
      @(posedge sys_clk);
      wdt_enabled <= wde;
      pulse(2);
      pulse(0);
      m = exp_mode(idl, fs, wde);
      chk(8'(mode), 8'(m), "halt mode");
      chk(8'(wdt_clear), 8'h01, "wdt clear");
      chk({6'h00, powerdown_flag, watchdog_timeout_flag}, 8'h02,
          "halt flags");
      count(64);
      chk(8'(cnt[3]), 8'h00, "cpu ticks");
      chk(8'(cnt[4] > 0), 8'(m == MODE_IDLE_CLK), "sys ticks");
      chk(8'(cnt[2] > 0), 8'(idl), "tbc ticks");
      chk(8'(cnt[1] > 0), 8'(wde), "wdt ticks");
      chk(8'(wdt_halt), 8'(m == MODE_DEEP_SLEEP), "wdt halt");
      chk(8'(low_osc_on), 8'(m != MODE_DEEP_SLEEP), "low osc");
      chk(8'(high_osc_on), 8'(m == MODE_IDLE_CLK), "high osc");
      rd(CA, d);
      chk(d & 8'he3, cv, "ctrl kept");
      if (m == MODE_DEEP_SLEEP)
        chk(8'(d[3]), 8'h00, "low ready in sleep");
      rd(AA, d);
      chk(d, {fs, 7'h00}, "aux kept");
      pulse(0);
      chk(8'(mode), 8'(m), "second halt");
      pulse(1);
      chk(8'(mode), 8'(MODE_RUN), "wake");
      repeat (12) @(posedge sys_clk);
      rd(CA, d);
      chk(8'(d[3]), 8'h01, "low ready after wake");
      pulse(3);
      chk(8'(powerdown_flag), 8'h00, "pdf clear");
    end
    finish_test();
  end

endmodule
`default_nettype wire
